// *** predriver_pkg.sv ***
// shared constants and carrier types for the pre-driver control/fault block
`default_nettype none
package predriver_pkg;

	// ------------------------------------------------------------
	// register addresses (3-bit frame address)
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL_C = 3'h3;
	localparam logic [2:0] ADDR_CTRL_D = 3'h4;
	localparam logic [2:0] ADDR_FAULT = 3'h5;
	localparam logic [2:0] ADDR_SUPPLY_STATUS = 3'h6;

	// ------------------------------------------------------------
	// serial frame layout
	// ------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] HEAD_BITS = 5'h04;
	localparam logic [4:0] CNT_OVER = 5'h11;
	localparam int POS_ADDR_HI = 15;
	localparam int POS_ADDR_LO = 13;
	localparam int POS_RW = 12;

	// ------------------------------------------------------------
	// fault register bit positions
	// ------------------------------------------------------------
	localparam int FB_SUMMARY = 0;
	localparam int FB_SHUTDOWN = 1;
	localparam int FB_LOW_SHORT = 2;
	localparam int FB_HIGH_SHORT = 5;
	localparam int FB_SUPPLY_WARN = 8;
	localparam int FB_LOCKOUT = 9;
	localparam int FB_THERM_WARN = 10;
	localparam int FB_PUMP = 11;
	localparam int F2_GATE = 0;
	localparam int F2_BOOT_C = 1;
	localparam int F2_BOOT_B = 2;
	localparam int F2_BOOT_A = 3;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [11:0] CTRL_C_RESET = 12'h01C;
	localparam logic [11:0] CTRL_D_RESET = 12'h000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RETRY_TIME_NS = 1000000;
	localparam int RETRY_CYCLES = RETRY_TIME_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic third_channel_short_protect_enable;
		logic [2:0] third_channel_sense_gain;
		logic [2:0] third_channel_blanking;
		logic [2:0] third_channel_dead_time;
		logic [1:0] third_channel_slew_rate;
	} ctrl_c_t;

	typedef struct packed {
		logic [2:0] third_channel_short_threshold;
		logic [2:0] second_channel_short_threshold;
		logic [2:0] first_channel_short_threshold;
		logic overcurrent_latch_mode;
		logic [1:0] sense_output_select;
	} ctrl_d_t;

	// asynchronous pin inputs; channel index 0 = A, 2 = C
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic sdi;
		logic thermal_shutdown;
		logic thermal_warn;
		logic supply_low_warn;
		logic supply_lockout;
		logic gate_supply_low;
		logic [2:0] low_short;
		logic [2:0] high_short;
		logic [2:0] bootstrap_low;
	} pins_t;

	localparam pins_t PINS_IDLE = 17'h08000;

endpackage : predriver_pkg

`default_nettype wire

// *** pin_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 17,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] safe;
	} sync_t;

	sync_t st;
	sync_t next_st;

	// first stage feeds only the second stage
	always_comb
	begin
		next_st.meta = i_async;
		next_st.safe = st.meta;
	end

	// idle level at reset so an idle bus looks deselected
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st <= {IDLE, IDLE};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign o_sync = st.safe;

endmodule : pin_sync

`default_nettype wire

// *** predriver_ctrl_fault_regs.sv ***
// control and fault registers with serial access and short retry timing
//
// Summary of operation
// RL1 - control register 3 holds two-bit slew rate in bits 1..0
// RL2 - bits 4..2 hold dead time, reset to all ones
// RL3 - bits 7..5 hold blanking time, reset zero
// RL4 - bits 10..8 hold sense amplifier gain, reset zero
// RL5 - bit 11 enables third channel short protection, reset off
// RL6 - register 4 bits 1..0 select sensed channel for output, reset zero
// RL7 - register 4 holds three-bit short thresholds for A, B, C
// RL8 - mode bit 2 set latches faulty output off, clear retries
// RL9 - fault bit 0 is read-only OR of other fault flags
// RL10 - thermal shutdown sets fault bit 1 until cleared
// RL11 - low-side shorts set bits 2, 3, 4 for A, B, C
// RL12 - high-side shorts set bits 5, 6, 7 for A, B, C
// RL13 - supply warning sets bit 8 until written clear
// RL14 - supply lockout sets bit 9, cleared by writing one
// RL15 - bit 10 reads thermal warning level, writes ignored
// RL16 - bit 11 shows charge pump; writing one toggles it
// RL17 - writing one clears a fault flag, zero leaves it
// RL18 - bootstrap low sets register 6 bits 3, 2, 1 for A, B, C
// RL19 - register 6 bit 0 reads gate supply low level
// RL20 - writing one clears a register 6 flag, zero no effect
// RL21 - 16-bit frame: 3 address, rw, 12 data, sampled on rising
// RL22 - in retry mode output stays off 1 ms then re-enables
// RL23 - fault indicator pin low while fault flags remain set
// RL24 - register 6 bits 11..4 read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none

module predriver_ctrl_fault_regs #(
	parameter int RETRY_CYCLES = predriver_pkg::RETRY_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire predriver_pkg::pins_t i_pins,
	input wire logic [1:0] i_short_protect_en_ab,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	output logic o_fault_indicator_pin_n,
	output predriver_pkg::ctrl_c_t o_channel_c_cfg,
	output predriver_pkg::ctrl_d_t o_ctrl_d,
	output logic [1:0] o_sense_output_select,
	output logic o_charge_pump_on,
	output logic [2:0] o_channel_off
);

	localparam int TW = $clog2(RETRY_CYCLES + 1);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the hold-off check below watches eight cycles of the off time
	if (RETRY_CYCLES < 8)
	begin : g_bad_retry
		$error("retry count must be at least eight cycles");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic sck_d;
		logic cs_n_d;
		logic [15:0] shift_in;
		logic [4:0] bit_cnt;
		logic [11:0] shift_out;
		logic sdo;
		predriver_pkg::ctrl_c_t ctrl_c;
		predriver_pkg::ctrl_d_t ctrl_d;
		logic [9:1] sticky;
		logic pump;
		logic [2:0] boot;
		logic [2:0] short_prev;
		logic [2:0] off;
		logic [2:0][TW-1:0] timer;
	} state_t;

	state_t st;
	state_t next_st;
	predriver_pkg::pins_t pin;

	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic wr_commit;
	logic [2:0] wr_addr;
	logic [11:0] wr_data;
	logic [11:0] clr;
	logic [11:0] fault_rd;
	logic [11:0] supply_rd;
	logic [11:0] rd_data;
	logic [9:1] set9;
	logic [9:1] sticky_nx;
	logic [2:0] clr_boot;
	logic [2:0] protect_en;
	logic [2:0] off_nx;
	logic [2:0][TW-1:0] timer_nx;
	logic [2:0] trip;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	pin_sync #(
		.WIDTH($bits(predriver_pkg::pins_t)),
		.IDLE(predriver_pkg::PINS_IDLE)
	) u_sync (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_async(i_pins),
		.o_sync(pin)
	);

	// link edges seen from the system clock
	assign sck_rise = pin.sck & ~st.sck_d;
	assign sck_fall = ~pin.sck & st.sck_d;
	assign cs_rise = pin.cs_n & ~st.cs_n_d;

	// a write lands only on a complete frame closed by deselect
	assign wr_commit = cs_rise && (st.bit_cnt == predriver_pkg::FRAME_BITS)
		&& st.shift_in[predriver_pkg::POS_RW]; // RL21
	assign wr_addr =
		st.shift_in[predriver_pkg::POS_ADDR_HI:predriver_pkg::POS_ADDR_LO];
	assign wr_data = st.shift_in[11:0];
	assign clr = wr_commit && (wr_addr == predriver_pkg::ADDR_FAULT)
		? wr_data : 12'h000;

	// ------------------------------------------------------------
	// fault flags
	// ------------------------------------------------------------
	// event sources in bit order 9..1
	assign set9 = {pin.supply_lockout, // RL14
		pin.supply_low_warn, // RL13
		pin.high_short, // RL12
		pin.low_short, // RL11
		pin.thermal_shutdown}; // RL10

	// set wins over a same-cycle clear so no event is lost
	assign sticky_nx = (st.sticky & ~clr[9:1]) | set9; // RL17

	// register 6 clears, channel a sits lowest
	assign clr_boot = wr_commit
		&& (wr_addr == predriver_pkg::ADDR_SUPPLY_STATUS)
		? {wr_data[predriver_pkg::F2_BOOT_C],
		wr_data[predriver_pkg::F2_BOOT_B],
		wr_data[predriver_pkg::F2_BOOT_A]} : 3'h0; // RL20

	// summary excludes thermal warning and pump; unlike the pin it ignores register 6
	assign fault_rd = {st.pump, pin.thermal_warn, // RL15
		st.sticky, |st.sticky}; // RL9
	assign supply_rd = {8'h00, // RL24
		st.boot[0], st.boot[1], st.boot[2], // RL18
		pin.gate_supply_low}; // RL19

	// read source chosen by the three address bits
	always_comb
	begin
		case (st.shift_in[2:0])
			predriver_pkg::ADDR_CTRL_C: rd_data = st.ctrl_c;
			predriver_pkg::ADDR_CTRL_D: rd_data = st.ctrl_d;
			predriver_pkg::ADDR_FAULT: rd_data = fault_rd;
			predriver_pkg::ADDR_SUPPLY_STATUS: rd_data = supply_rd;
			default: rd_data = 12'h000;
		endcase
	end

	// ------------------------------------------------------------
	// per-channel short protection
	// ------------------------------------------------------------
	// channels a and b take their enables from the i_short_protect_en_ab port
	assign protect_en = {
		st.ctrl_c.third_channel_short_protect_enable, // RL5
		i_short_protect_en_ab};

	for (genvar ch = 0; ch < 3; ch++)
	begin : g_chan
		logic flagged;

		// only a fresh short trips, a held one re-trips nothing
		assign trip[ch] = (pin.low_short[ch] | pin.high_short[ch])
			& ~st.short_prev[ch] & protect_en[ch];
		assign flagged = sticky_nx[predriver_pkg::FB_LOW_SHORT + ch]
			| sticky_nx[predriver_pkg::FB_HIGH_SHORT + ch];

		// latch holds until flags clear; retry counts down
		always_comb
		begin
			off_nx[ch] = st.off[ch];
			timer_nx[ch] = st.timer[ch];
			if (trip[ch])
			begin
				off_nx[ch] = 1'b1;
				timer_nx[ch] = TW'(RETRY_CYCLES);
			end
			else if (st.off[ch])
			begin
				if (st.ctrl_d.overcurrent_latch_mode)
				begin
					off_nx[ch] = flagged; // RL8
				end
				else if (st.timer[ch] <= TW'(1))
				begin
					off_nx[ch] = 1'b0; // RL22
					timer_nx[ch] = '0;
				end
				else
				begin
					timer_nx[ch] = st.timer[ch] - TW'(1); // RL22
				end
			end
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.sck_d = pin.sck;
		next_st.cs_n_d = pin.cs_n;
		// frame engine: shift on rising, present data on falling
		if (pin.cs_n)
		begin
			next_st.bit_cnt = 5'h00;
			next_st.sdo = 1'b0;
		end
		else if (sck_rise)
		begin
			next_st.shift_in = {st.shift_in[14:0], pin.sdi}; // RL21
			if (st.bit_cnt != predriver_pkg::CNT_OVER)
			begin
				next_st.bit_cnt = st.bit_cnt + 5'h01;
			end
			if (st.bit_cnt == predriver_pkg::HEAD_BITS - 5'h01)
			begin
				next_st.shift_out = rd_data;
			end
		end
		else if (sck_fall && st.bit_cnt >= predriver_pkg::HEAD_BITS
			&& st.bit_cnt <= predriver_pkg::FRAME_BITS)
		begin
			next_st.sdo = st.shift_out[11];
			next_st.shift_out = {st.shift_out[10:0], 1'b0};
		end
		// control writes
		if (wr_commit && wr_addr == predriver_pkg::ADDR_CTRL_C)
		begin
			next_st.ctrl_c = wr_data; // RL1 RL2 RL3 RL4 RL5
		end
		if (wr_commit && wr_addr == predriver_pkg::ADDR_CTRL_D)
		begin
			next_st.ctrl_d = wr_data; // RL6 RL7 RL8
		end
		// flags and pump toggle
		next_st.sticky = sticky_nx;
		next_st.pump = st.pump ^ clr[predriver_pkg::FB_PUMP]; // RL16
		next_st.boot = (st.boot & ~clr_boot) | pin.bootstrap_low; // RL18
		next_st.short_prev = pin.low_short | pin.high_short;
		next_st.off = off_nx;
		next_st.timer = timer_nx;
	end

	// registers; dead time comes out of reset all ones
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st <= '0;
			st.cs_n_d <= 1'b1;
			st.ctrl_c <= predriver_pkg::CTRL_C_RESET; // RL2
			st.ctrl_d <= predriver_pkg::CTRL_D_RESET; // RL6
		end
		else
		begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_sdo = st.sdo;
	assign o_sdo_oe_n = st.cs_n_d;
	assign o_channel_c_cfg = st.ctrl_c;
	assign o_ctrl_d = st.ctrl_d;
	assign o_sense_output_select = st.ctrl_d.sense_output_select; // RL6
	assign o_charge_pump_on = st.pump;
	assign o_channel_off = st.off;
	// gate supply level also pulls the pin, thermal warning does not
	assign o_fault_indicator_pin_n = ~(|st.sticky | |st.boot
		| pin.gate_supply_low); // RL23

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence s_write(logic [2:0] a);
		wr_commit && (wr_addr == a);
	endsequence

	sequence s_retry_trip;
		trip[2] && !st.ctrl_d.overcurrent_latch_mode;
	endsequence

	a_ctrl_c_load: // RL1 RL2 RL3 RL4 RL5
	assert property (s_write(predriver_pkg::ADDR_CTRL_C)
		|=> o_channel_c_cfg == $past(wr_data))
		else $error("channel c config not loaded");

	a_ctrl_d_load: // RL6 RL7
	assert property (s_write(predriver_pkg::ADDR_CTRL_D)
		|=> o_ctrl_d == $past(wr_data))
		else $error("sense and threshold register not loaded");

	a_shutdown_set_wins: // RL10 RL17
	assert property (pin.thermal_shutdown |=> st.sticky[1]
		##0 !o_fault_indicator_pin_n)
		else $error("shutdown flag lost");

	a_warn_clear_one: // RL13 RL17
	assert property (s_write(predriver_pkg::ADDR_FAULT)
		##0 (wr_data[8] && !pin.supply_low_warn) |=> !st.sticky[8])
		else $error("supply warning not cleared");

	a_summary_clears: // RL9
	assert property (s_write(predriver_pkg::ADDR_FAULT)
		##0 (wr_data[9:1] == 9'h1FF && set9 == 9'h000)
		|=> !fault_rd[0])
		else $error("summary bit stuck");

	a_pump_toggle: // RL16
	assert property (s_write(predriver_pkg::ADDR_FAULT) ##0 wr_data[11]
		|=> o_charge_pump_on != $past(o_charge_pump_on))
		else $error("charge pump did not toggle");

	a_boot_clear: // RL20
	assert property (s_write(predriver_pkg::ADDR_SUPPLY_STATUS)
		##0 (wr_data[3] && !pin.bootstrap_low[0]) |=> !st.boot[0])
		else $error("bootstrap flag not cleared");

	a_spare_bits_zero: // RL24
	assert property ((sck_rise && !pin.cs_n
		&& st.bit_cnt == predriver_pkg::HEAD_BITS - 5'h01
		&& st.shift_in[2:0] == predriver_pkg::ADDR_SUPPLY_STATUS)
		|=> st.shift_out[11:4] == 8'h00)
		else $error("unused bits not zero");

	a_retry_hold_off: // RL22
	assert property (s_retry_trip |=> o_channel_off[2] [*8])
		else $error("retry released too early");

	a_retry_release: // RL22
	assert property ((st.off[2] && !st.ctrl_d.overcurrent_latch_mode
		&& st.timer[2] == TW'(1) && !trip[2]) |=> !o_channel_off[2])
		else $error("retry did not release");

	a_latch_hold: // RL8
	assert property ((st.off[2] && st.ctrl_d.overcurrent_latch_mode
		&& (sticky_nx[4] || sticky_nx[7])) |=> o_channel_off[2])
		else $error("latched output re-enabled");

	a_fault_pin_low: // RL23
	assert property ((|st.sticky) |-> !o_fault_indicator_pin_n)
		else $error("fault pin not driven");

endmodule : predriver_ctrl_fault_regs

`default_nettype wire

// *** host_spi_model.sv ***
// host-side serial master model for the register link
`timescale 1ns/100ps
`default_nettype none

module host_spi_model (
	input wire logic i_clk,
	input wire logic i_sdo,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_sdi
);
	// ------------------------------------------------------------
	// idle link
	// ------------------------------------------------------------
	// sck rests low outside frames
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_sdi = 1'b0;
	end

	// wait falling edges of the system clock
	task automatic gap(input int n);
		repeat (n) @(negedge i_clk);
	endtask : gap

	// one frame; four clocks a half period gives a 64 ns link clock
	task automatic xfer(input logic [2:0] addr, input logic wr,
		input logic [11:0] wdata, output logic [11:0] rdata);
		logic [15:0] frame;
		frame = {addr, wr, wdata};
		rdata = 12'h000;
		gap(1);
		o_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			o_sdi = frame[i];
			gap(4);
			o_sck = 1'b1;
			if (i < 12)
				rdata[i] = i_sdo;
			gap(4);
			o_sck = 1'b0;
		end
		gap(4);
		o_cs_n = 1'b1;
		// released line flips so a stale bit is never mistaken for data
		o_sdi = ~o_sdi;
		gap(8);
	endtask : xfer
endmodule : host_spi_model
`default_nettype wire

// *** predriver_ctrl_fault_regs_tb.sv ***
// self-checking bench for the control and fault registers
`timescale 1ns/100ps
`default_nettype none

module predriver_ctrl_fault_regs_tb;
	localparam int RETRY = 20;
	logic clk, nrst, sck, cs_n, sdi, sdo, sdo_oe_n, fault_n, pump_on;
	logic [1:0] en_ab, sense_sel;
	logic [2:0] chan_off;
	predriver_pkg::pins_t flt, pins;
	predriver_pkg::ctrl_c_t cfg_c;
	predriver_pkg::ctrl_d_t ctrl_d;
	int bad_count, samples_checked, width;

	// ------------------------------------------------------------
	// wiring
	// ------------------------------------------------------------
	// link pins from the host, fault levels from the bench
	always_comb
	begin
		pins = flt;
		pins.sck = sck;
		pins.cs_n = cs_n;
		pins.sdi = sdi;
	end

	predriver_ctrl_fault_regs #(.RETRY_CYCLES(RETRY)) dut_u (
		.i_clk(clk), .i_nrst(nrst), .i_pins(pins),
		.i_short_protect_en_ab(en_ab), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
		.o_fault_indicator_pin_n(fault_n), .o_channel_c_cfg(cfg_c),
		.o_ctrl_d(ctrl_d), .o_sense_output_select(sense_sel),
		.o_charge_pump_on(pump_on), .o_channel_off(chan_off));

	host_spi_model host_u (.i_clk(clk), .i_sdo(sdo), .o_sck(sck),
		.o_cs_n(cs_n), .o_sdi(sdi));

	// 125 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		logic [11:0] q;
		host_u.xfer(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input string what, input logic [2:0] a,
		input logic [11:0] exp);
		logic [11:0] q;
		host_u.xfer(a, 1'b0, 12'h000, q);
		check(what, q, exp);
	endtask : rd

	// fault sources 1..9 follow fault bits, 11..13 bootstrap flags C..A
	task automatic set_flt(input int k, input logic v);
		case (k)
			1: flt.thermal_shutdown = v;
			2, 3, 4: flt.low_short[k-2] = v;
			5, 6, 7: flt.high_short[k-5] = v;
			8: flt.supply_low_warn = v;
			9: flt.supply_lockout = v;
			default: flt.bootstrap_low[13-k] = v;
		endcase
	endtask : set_flt

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	// main sequence of register and fault scenarios
	initial
	begin
		nrst = 1'b0;
		flt = predriver_pkg::PINS_IDLE;
		en_ab = 2'b11;
		bad_count = 0;
		samples_checked = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check("cfg_c reset", cfg_c, 12'h01C);
		check("oe idle", {11'h000, sdo_oe_n}, 12'h001);
		// output enable must drop while the frame is in flight
		fork
			rd("reg3 reset", predriver_pkg::ADDR_CTRL_C, 12'h01C);
			begin
				repeat (40) @(negedge clk);
				check("oe drive", {11'h000, sdo_oe_n}, 12'h000);
			end
		join
		rd("reg4 reset", predriver_pkg::ADDR_CTRL_D, 12'h000);
		rd("reg5 reset", predriver_pkg::ADDR_FAULT, 12'h000);
		rd("reg6 reset", predriver_pkg::ADDR_SUPPLY_STATUS, 12'h000);
		// two complementary patterns per control register
		wr(predriver_pkg::ADDR_CTRL_C, 12'h5A4);
		rd("reg3 a", predriver_pkg::ADDR_CTRL_C, 12'h5A4);
		check("cfg_c a", cfg_c, 12'h5A4);
		wr(predriver_pkg::ADDR_CTRL_C, 12'hA5B);
		check("cfg_c b", cfg_c, 12'hA5B);
		wr(predriver_pkg::ADDR_CTRL_D, 12'hB69);
		rd("reg4 a", predriver_pkg::ADDR_CTRL_D, 12'hB69);
		check("mux a", {10'h000, sense_sel}, 12'h001);
		wr(predriver_pkg::ADDR_CTRL_D, 12'h496);
		check("ctrl_d b", ctrl_d, 12'h496);
		check("mux b", {10'h000, sense_sel}, 12'h002);
		// unmapped addresses keep nothing and alias nothing
		for (int a = 0; a < 8; a = (a == 2) ? 7 : a + 1)
		begin
			wr(3'(a), 12'hFFF);
			rd("unmapped", 3'(a), 12'h000);
		end
		rd("reg3 kept", predriver_pkg::ADDR_CTRL_C, 12'hA5B);
		// every sticky flag: set, write zero, write one
		for (int k = 1; k <= 9; k++)
		begin
			set_flt(k, 1'b1);
			repeat (6) @(negedge clk);
			set_flt(k, 1'b0);
			rd("flag set", predriver_pkg::ADDR_FAULT, 12'h001 | (12'h001 << k));
			check("pin low", {11'h000, fault_n}, 12'h000);
			wr(predriver_pkg::ADDR_FAULT, 12'h000);
			rd("flag kept", predriver_pkg::ADDR_FAULT, 12'h001 | (12'h001 << k));
			wr(predriver_pkg::ADDR_FAULT, 12'h001 << k);
			rd("flag clear", predriver_pkg::ADDR_FAULT, 12'h000);
			check("pin high", {11'h000, fault_n}, 12'h001);
		end
		// thermal warning is a live level, immune to writes
		flt.thermal_warn = 1'b1;
		wr(predriver_pkg::ADDR_FAULT, 12'h400);
		rd("warn live", predriver_pkg::ADDR_FAULT, 12'h400);
		flt.thermal_warn = 1'b0;
		rd("warn gone", predriver_pkg::ADDR_FAULT, 12'h000);
		// pump bit toggles on one, holds on zero
		wr(predriver_pkg::ADDR_FAULT, 12'h800);
		wr(predriver_pkg::ADDR_FAULT, 12'h000);
		rd("pump on", predriver_pkg::ADDR_FAULT, 12'h800);
		check("pump pin", {11'h000, pump_on}, 12'h001);
		wr(predriver_pkg::ADDR_FAULT, 12'h800);
		rd("pump off", predriver_pkg::ADDR_FAULT, 12'h000);
		// bootstrap flags, then gate supply level with unused bits
		for (int k = 11; k <= 13; k++)
		begin
			set_flt(k, 1'b1);
			repeat (6) @(negedge clk);
			set_flt(k, 1'b0);
			rd("boot set", predriver_pkg::ADDR_SUPPLY_STATUS,
				12'h001 << (k - 10));
			check("boot pin", {11'h000, fault_n}, 12'h000);
			wr(predriver_pkg::ADDR_SUPPLY_STATUS, 12'h000);
			rd("boot kept", predriver_pkg::ADDR_SUPPLY_STATUS,
				12'h001 << (k - 10));
			wr(predriver_pkg::ADDR_SUPPLY_STATUS, 12'h001 << (k - 10));
			rd("boot clear", predriver_pkg::ADDR_SUPPLY_STATUS, 12'h000);
		end
		flt.gate_supply_low = 1'b1;
		wr(predriver_pkg::ADDR_SUPPLY_STATUS, 12'hFFF);
		rd("gate live", predriver_pkg::ADDR_SUPPLY_STATUS, 12'h001);
		check("gate pin", {11'h000, fault_n}, 12'h000);
		flt.gate_supply_low = 1'b0;
		rd("gate gone", predriver_pkg::ADDR_SUPPLY_STATUS, 12'h000);
		// latch mode: channel C stays off until its flag is cleared
		set_flt(7, 1'b1);
		repeat (4) @(negedge clk);
		set_flt(7, 1'b0);
		repeat (3 * RETRY) @(negedge clk);
		check("latched", {9'h000, chan_off}, 12'h004);
		wr(predriver_pkg::ADDR_FAULT, 12'h080);
		check("unlatched", {9'h000, chan_off}, 12'h000);
		// retry mode: each channel off for exactly the retry time
		wr(predriver_pkg::ADDR_CTRL_D, 12'hB69);
		for (int c = 0; c < 3; c++)
		begin
			width = 0;
			for (int n = 0; n < 5 * RETRY; n++)
			begin
				set_flt(c + 2, n < 4);
				@(negedge clk);
				if (chan_off[c] === 1'b1)
					width++;
			end
			check("retry span", 12'(width), 12'(RETRY));
			wr(predriver_pkg::ADDR_FAULT, 12'h001 << (c + 2));
		end
		// protection off: fresh shorts still flag but switch nothing off
		en_ab = 2'b00;
		wr(predriver_pkg::ADDR_CTRL_C, 12'h25B);
		for (int k = 1; k <= 9; k = (k == 4) ? 9 : k + 1)
			set_flt(k, 1'b1);
		repeat (6) @(negedge clk);
		for (int k = 1; k <= 9; k = (k == 4) ? 9 : k + 1)
			set_flt(k, 1'b0);
		check("no trip", {9'h000, chan_off}, 12'h000);
		rd("many set", predriver_pkg::ADDR_FAULT, 12'h21F);
		// one write clears every sticky flag and the summary with them
		wr(predriver_pkg::ADDR_FAULT, 12'h3FE);
		rd("all clear", predriver_pkg::ADDR_FAULT, 12'h000);
		end_sim();
	end

	// watchdog well beyond the expected run length
	initial
	begin
		#400000;
		bad_count++;
		end_sim();
	end
endmodule : predriver_ctrl_fault_regs_tb
`default_nettype wire
